// ===== src/cpa_regs.sv
`timescale 1ns/10ps
`include "cpa_cfg.svh"

module cpa_regs #(
  parameter logic [2:0] REV_ID = `CPA_REV_ID
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire cpa_pkg::cpa_req_t req,
  input  wire cpa_pkg::cpa_stat_t stat,
  input  wire logic              wclk_tick,
  output logic [`CPA_DW-1:0]     rd_data,
  output logic                   rd_valid,
  output cpa_pkg::cpa_ctrl_t     ctrl
);

  // ==========================================
  // access decode
  logic                   wr_ctl2;
  logic                   wr_pwr;
  logic                   wr_ctl3;
  logic                   rd_ctl3;

  assign wr_ctl2 = req.wr && (req.addr == `CPA_OFS_CTL2);
  assign wr_pwr  = req.wr && (req.addr == `CPA_OFS_PWR);
  assign wr_ctl3 = req.wr && (req.addr == `CPA_OFS_CTL3);
  assign rd_ctl3 = req.rd && (req.addr == `CPA_OFS_CTL3);

  // ==========================================
  // register state
  logic                   step_slow_q;
  logic [`CPA_NUM_PWR-1:0] pwr_q;
  logic [3:0]             done_q;
  logic                   effects_q;
  logic                   deemph_q;
  logic [1:0]             vol_q;
  logic                   ref_q;
  logic                   xfer_q;
  logic                   role_q;
  logic [`CPA_NUM_OVF-1:0] ovf_q;
  logic [1:0]             rsv_q;
  logic                   clip_q;

  // derived outputs, each held in its own flop; rd_data_d and flag_d are combinational
  logic                   half_q;
  logic                   step_q;
  logic                   all_off_q;
  logic                   l_from_r_q;
  logic                   r_from_l_q;
  logic                   clip_act_q;
  logic [`CPA_DW-1:0]     rd_data_q;
  logic [`CPA_DW-1:0]     rd_data_d;
  logic                   rd_valid_q;
  logic                   flag_d;

  // ==========================================
  // control 2 tail
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      step_slow_q <= `CPA_BIT_RST;
    end else if (wr_ctl2) begin
      step_slow_q <= req.wdata[`CPA_STEP_BIT];
    end
  end

  // slow rate skips every other word clock; the phase flop runs
  // freely so a rate change takes effect on the next tick
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      half_q <= `CPA_BIT_RST;
      step_q <= `CPA_BIT_RST;
    end else begin
      if (wclk_tick) begin
        half_q <= ~half_q;
      end
      step_q <= wclk_tick && (!step_slow_q || half_q);
    end
  end

  // saturation replaces the settled meaning while gain control runs
  always_comb begin
    if (stat.agc_on) begin
      flag_d = stat.agc_saturated;
    end else begin
      flag_d = stat.gain_settled;
    end
  end

  // ==========================================
  // power register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwr_q <= `CPA_PWR_RST;
    end else if (wr_pwr) begin
      pwr_q <= req.wdata[`CPA_PWR_MSB:`CPA_PWR_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      effects_q <= `CPA_BIT_RST;
    end else if (wr_pwr) begin
      effects_q <= req.wdata[`CPA_EFF_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      deemph_q <= `CPA_BIT_RST;
    end else if (wr_pwr) begin
      deemph_q <= req.wdata[`CPA_DEEMPH_BIT];
    end
  end

  // done flags follow the analog side, writes never reach them
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_q <= `CPA_DONE_RST;
    end else begin
      done_q <= stat.off_done;
    end
  end

  // one cycle behind the power bits; analog settles far slower
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      all_off_q <= `CPA_BIT_SET;
    end else begin
      all_off_q <= &pwr_q;
    end
  end

  // ==========================================
  // control 3
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      vol_q <= `CPA_VOL_RST;
    end else if (wr_ctl3) begin
      vol_q <= req.wdata[`CPA_VOL_MSB:`CPA_VOL_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ref_q <= `CPA_BIT_RST;
    end else if (wr_ctl3) begin
      ref_q <= req.wdata[`CPA_REF_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      xfer_q <= `CPA_BIT_RST;
    end else if (wr_ctl3) begin
      xfer_q <= req.wdata[`CPA_XFER_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      role_q <= `CPA_BIT_RST;
    end else if (wr_ctl3) begin
      role_q <= req.wdata[`CPA_ROLE_BIT];
    end
  end

  // reserved pair is plain storage, nothing downstream reads it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rsv_q <= `CPA_RSV_RST;
    end else if (wr_ctl3) begin
      rsv_q <= req.wdata[`CPA_RSV_MSB:`CPA_RSV_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clip_q <= `CPA_BIT_RST;
    end else if (wr_ctl3) begin
      clip_q <= req.wdata[`CPA_CLIP_BIT];
    end
  end

  // codes 00 and 11 both leave the channels independent
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      l_from_r_q <= `CPA_BIT_RST;
      r_from_l_q <= `CPA_BIT_RST;
    end else begin
      l_from_r_q <= (vol_q == `CPA_VOL_L_FROM_R);
      r_from_l_q <= (vol_q == `CPA_VOL_R_FROM_L);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clip_act_q <= `CPA_BIT_RST;
    end else begin
      clip_act_q <= clip_q && stat.agc_on;
    end
  end

  // ==========================================
  // sticky overflow flags
  // a new event in the clearing read's cycle survives the clear
  genvar gi;
  generate
    for (gi = 0; gi < `CPA_NUM_OVF; gi++) begin : g_ovf
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          ovf_q[gi] <= `CPA_BIT_RST;
        end else if (stat.ovf_evt[gi]) begin
          ovf_q[gi] <= 1'h1;
        end else if (rd_ctl3) begin
          ovf_q[gi] <= 1'h0;
        end
      end
    end
  endgenerate

  // ==========================================
  // read path
  always_comb begin
    rd_data_d = `CPA_ZERO16;
    case (req.addr)
      `CPA_OFS_CTL2: begin
        rd_data_d[`CPA_STEP_BIT] = step_slow_q;
        rd_data_d[`CPA_FLAG_BIT] = flag_d;
      end
      `CPA_OFS_PWR: begin
        rd_data_d[`CPA_PWR_MSB:`CPA_PWR_LSB]   = pwr_q;
        rd_data_d[`CPA_DONE_MSB:`CPA_DONE_LSB] = done_q;
        rd_data_d[`CPA_EFF_BIT]                = effects_q;
        rd_data_d[`CPA_DEEMPH_BIT]             = deemph_q;
      end
      `CPA_OFS_CTL3: begin
        rd_data_d[`CPA_VOL_MSB:`CPA_VOL_LSB] = vol_q;
        rd_data_d[`CPA_REF_BIT]              = ref_q;
        rd_data_d[`CPA_XFER_BIT]             = xfer_q;
        rd_data_d[`CPA_ROLE_BIT]             = role_q;
        rd_data_d[`CPA_OVF_MSB:`CPA_OVF_LSB] = ovf_q;
        rd_data_d[`CPA_RSV_MSB:`CPA_RSV_LSB] = rsv_q;
        rd_data_d[`CPA_CLIP_BIT]             = clip_q;
        rd_data_d[`CPA_REV_MSB:`CPA_REV_LSB] = REV_ID;
      end
      default: begin
        rd_data_d = `CPA_ZERO16;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_valid_q <= `CPA_BIT_RST;
    end else begin
      rd_valid_q <= req.rd;
    end
  end

  // data held until the next read so a slow serial side can shift it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_q <= `CPA_ZERO16;
    end else if (req.rd) begin
      rd_data_q <= rd_data_d;
    end
  end

  // ==========================================
  // outputs, all straight from flops
  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;

  assign ctrl.gain_step_slow      = step_slow_q;
  assign ctrl.gain_step           = step_q;
  assign ctrl.block_off           = pwr_q;
  assign ctrl.codec_all_off       = all_off_q;
  assign ctrl.effects_on          = effects_q;
  assign ctrl.deemphasis_on       = deemph_q;
  assign ctrl.left_vol_from_right = l_from_r_q;
  assign ctrl.right_vol_from_left = r_from_l_q;
  assign ctrl.ref_rate_44k1       = ref_q;
  assign ctrl.block_transfer      = xfer_q;
  assign ctrl.codec_master        = role_q;
  assign ctrl.clip_step_active    = clip_act_q;

endmodule : cpa_regs

// ===== src/cpa_cfg.svh
`ifndef CPA_CFG_SVH
`define CPA_CFG_SVH

// ==========================================
// register port geometry
`define CPA_AW          7
`define CPA_DW          16
`define CPA_OFS_CTL2    7'h04
`define CPA_OFS_PWR     7'h05
`define CPA_OFS_CTL3    7'h06

// ==========================================
// control 2 tail fields
`define CPA_STEP_BIT    1
`define CPA_FLAG_BIT    0

// ==========================================
// power register fields
`define CPA_PWR_MSB     15
`define CPA_PWR_LSB     6
`define CPA_DONE_MSB    5
`define CPA_DONE_LSB    2
`define CPA_EFF_BIT     1
`define CPA_DEEMPH_BIT  0

// ==========================================
// control 3 fields
`define CPA_VOL_MSB     15
`define CPA_VOL_LSB     14
`define CPA_REF_BIT     13
`define CPA_XFER_BIT    12
`define CPA_ROLE_BIT    11
`define CPA_OVF_MSB     8
`define CPA_OVF_LSB     6
`define CPA_RSV_MSB     5
`define CPA_RSV_LSB     4
`define CPA_CLIP_BIT    3
`define CPA_REV_MSB     2
`define CPA_REV_LSB     0

// ==========================================
// reset values and encodings
`define CPA_PWR_RST     10'h3ff
`define CPA_DONE_RST    4'hf
`define CPA_VOL_RST     2'h0
`define CPA_RSV_RST     2'h0
`define CPA_BIT_RST     1'h0
`define CPA_BIT_SET     1'h1
`define CPA_ZERO16      16'h0000
`define CPA_VOL_L_FROM_R 2'h1
`define CPA_VOL_R_FROM_L 2'h2
`define CPA_NUM_PWR     10
`define CPA_NUM_OVF     3
// arbitrary value, not tied to any real silicon
`define CPA_REV_ID      3'h5

`endif

// ===== src/cpa_pkg.sv
`include "cpa_cfg.svh"

package cpa_pkg;

  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [`CPA_AW-1:0]     addr;
    logic [`CPA_DW-1:0]     wdata;
  } cpa_req_t;

  // off_done: adc, left dac, right dac, sidetone (msb first)
  // ovf_evt : adc, left dac, right dac (msb first)
  typedef struct packed {
    logic                   gain_settled;
    logic                   agc_on;
    logic                   agc_saturated;
    logic [3:0]             off_done;
    logic [2:0]             ovf_evt;
  } cpa_stat_t;

  typedef struct packed {
    logic                   gain_step_slow;
    logic                   gain_step;
    logic [9:0]             block_off;
    logic                   codec_all_off;
    logic                   effects_on;
    logic                   deemphasis_on;
    logic                   left_vol_from_right;
    logic                   right_vol_from_left;
    logic                   ref_rate_44k1;
    logic                   block_transfer;
    logic                   codec_master;
    logic                   clip_step_active;
  } cpa_ctrl_t;

endpackage : cpa_pkg

// ===== verification/cpa_regs_assertions.sv
`timescale 1ns/10ps
module cpa_regs_assertions #(
  parameter logic [2:0] REV_ID = 3'h0
) (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire cpa_pkg::cpa_req_t  req,
  input wire cpa_pkg::cpa_stat_t stat,
  input wire logic               wclk_tick,
  input wire logic [15:0]        rd_data,
  input wire logic               rd_valid,
  input wire cpa_pkg::cpa_ctrl_t ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic w5, w6, r4, r6;
  assign w5 = req.wr && req.addr == 7'h05;
  assign w6 = req.wr && req.addr == 7'h06;
  assign r4 = req.rd && req.addr == 7'h04;
  assign r6 = req.rd && req.addr == 7'h06;
  // ==========================================
  // control outputs
  a_power_write: assert property (w5 |=>
    ctrl.block_off == $past(req.wdata[15:6])) else $error("power bits");
  a_all_off: assert property (
    ctrl.codec_all_off == $past(&ctrl.block_off)) else $error("all off");
  a_mode_write: assert property (w6 |=>
    {ctrl.ref_rate_44k1, ctrl.block_transfer, ctrl.codec_master}
    == $past(req.wdata[13:11])) else $error("mode bits");
  a_vol_link: assert property (w6 |-> ##2
    {ctrl.left_vol_from_right, ctrl.right_vol_from_left} ==
    {$past(req.wdata[15:14], 2) == 2'h1, $past(req.wdata[15:14], 2) == 2'h2})
    else $error("volume link");
  a_fast_step: assert property (
    !ctrl.gain_step_slow && wclk_tick |=> ctrl.gain_step)
    else $error("missed step");
  a_rate_write: assert property (
    req.wr && req.addr == 7'h04 |=>
    ctrl.gain_step_slow == $past(req.wdata[1])) else $error("rate bit");
  a_step_on_tick: assert property (
    ctrl.gain_step |-> $past(wclk_tick)) else $error("stray step");
  a_filter_write: assert property (w5 |=>
    {ctrl.effects_on, ctrl.deemphasis_on} == $past(req.wdata[1:0]))
    else $error("filter bits");
  // ==========================================
  // reads
  a_rev_read: assert property (r6 |=>
    rd_valid && rd_data[2:0] == REV_ID) else $error("revision");
  a_gain_flag: assert property (r4 |=> rd_data[0] ==
    $past(stat.agc_on ? stat.agc_saturated : stat.gain_settled))
    else $error("gain flag");
  // read clears only what it has shown; new events must still land
  a_ovf_clear: assert property (
    r6 && stat.ovf_evt == 3'h0 ##1 stat.ovf_evt == 3'h0 ##1 r6
    |=> rd_data[8:6] == 3'h0) else $error("overflow not cleared");
  a_ovf_catch: assert property (
    stat.ovf_evt != 3'h0 ##1 !r6 ##1 r6 |=>
    (rd_data[8:6] & $past(stat.ovf_evt, 3)) == $past(stat.ovf_evt, 3))
    else $error("overflow lost");
  c_slow_step: cover property (ctrl.gain_step_slow && wclk_tick);
  c_ovf_seen: cover property (rd_valid && rd_data[8:6] != 3'h0);
  c_all_on: cover property (!ctrl.codec_all_off);
endmodule : cpa_regs_assertions

bind cpa_regs cpa_regs_assertions #(.REV_ID(REV_ID)) cpa_regs_assertions_i (
  .clk(clk), .reset_n(reset_n), .req(req), .stat(stat),
  .wclk_tick(wclk_tick), .rd_data(rd_data), .rd_valid(rd_valid),
  .ctrl(ctrl));

// ===== verification/cpa_regs_tb.sv
`timescale 1ns/10ps
module cpa_regs_tb;
  typedef struct packed {
    logic [6:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } cpa_row_t;
  // expected values below assume rev 2, and done flags 4'ha until stat switches to 4'h3
  localparam logic [2:0] REV = 3'h2;
  logic               clk;
  logic               reset_n;
  cpa_pkg::cpa_req_t  req;
  cpa_pkg::cpa_stat_t stat;
  logic               wclk_tick;
  logic [15:0]        rd_data;
  logic               rd_valid;
  cpa_pkg::cpa_ctrl_t ctrl;
  int                 num_errors;
  int                 n_checks;
  int                 steps;
  cpa_row_t rows [8] = '{
    '{7'h05, 16'hffff, 16'hffeb}, '{7'h05, 16'h5541, 16'h5569},
    '{7'h05, 16'h0000, 16'h0028}, '{7'h06, 16'hffff, 16'hf83a},
    '{7'h06, 16'h4000, 16'h4002}, '{7'h04, 16'hffff, 16'h0003},
    '{7'h04, 16'h0000, 16'h0001}, '{7'h07, 16'hffff, 16'h0000}};

  cpa_regs #(.REV_ID(REV)) cpa_regs_i (
    .clk(clk), .reset_n(reset_n), .req(req), .stat(stat),
    .wclk_tick(wclk_tick), .rd_data(rd_data), .rd_valid(rd_valid),
    .ctrl(ctrl));

  always #12.5 clk = ~clk;

  // ==========================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    #2 req.wr = 1'h1;
    req.addr = a;
    req.wdata = d;
    @(posedge clk);
    #2 req.wr = 1'h0;
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(posedge clk);
    #2 req.rd = 1'h1;
    req.addr = a;
    @(posedge clk);
    #2 req.rd = 1'h0;
    chk({15'h0000, rd_valid}, 16'h0001);
    chk(rd_data, e);
  endtask : rd

  task automatic tick;
    @(posedge clk);
    #2 wclk_tick = 1'h1;
    @(posedge clk);
    #2 wclk_tick = 1'h0;
    steps += ctrl.gain_step;
  endtask : tick

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // ==========================================
  // tests
  initial begin
    clk = 1'h0;
    reset_n = 1'h0;
    req = '0;
    wclk_tick = 1'h0;
    stat = {1'h1, 2'h0, 4'ha, 3'h0};
    num_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    #2 reset_n = 1'h1;
    chk({5'h00, ctrl.codec_all_off, ctrl.block_off}, 16'h07ff);
    rd(7'h05, 16'hffe8);
    rd(7'h06, 16'h0002);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("test reset and rows done");
    for (int v = 0; v < 4; v++) begin
      wr(7'h06, {v[1:0], 14'h0000});
      @(posedge clk);
      #2 chk({14'h0000, ctrl.left_vol_from_right, ctrl.right_vol_from_left},
        {14'h0000, v == 1, v == 2});
    end
    @(posedge clk);
    #2 stat.ovf_evt = 3'h5;
    @(posedge clk);
    #2 stat.ovf_evt = 3'h0;
    rd(7'h06, 16'hc142);
    rd(7'h06, 16'hc002);
    $display("test volume and overflow done");
    steps = 0;
    repeat (4) tick;
    chk(16'(steps), 16'h0004);
    wr(7'h04, 16'h0002);
    chk({15'h0000, ctrl.gain_step_slow}, 16'h0001);
    steps = 0;
    repeat (4) tick;
    chk(16'(steps), 16'h0002);
    stat = {1'h0, 2'h3, 4'h3, 3'h0};
    rd(7'h04, 16'h0003);
    wr(7'h06, 16'h0008);
    @(posedge clk);
    #2 chk({15'h0000, ctrl.clip_step_active}, 16'h0001);
    stat.agc_on = 1'h0;
    rd(7'h04, 16'h0002);
    chk({15'h0000, ctrl.clip_step_active}, 16'h0000);
    rd(7'h05, 16'h000c);
    $display("test step and gain done");
    // second reset in mid-run must restore the reset values
    reset_n = 1'h0;
    repeat (3) @(posedge clk);
    #2 reset_n = 1'h1;
    rd(7'h05, 16'hffcc);
    rd(7'h06, 16'h0002);
    rd(7'h04, 16'h0000);
    $display("test second reset done");
    final_report;
  end

  initial begin
    #(25 * 3000);
    num_errors++;
    $display("unexpected at %0t: timeout", $time);
    final_report;
  end
endmodule : cpa_regs_tb
